// *** rtl/spm_pkg.sv ***
// Shared constants and types for the serial master/slave core
package spm_pkg;
  localparam int SPM_DATA_W = 16;
  localparam int SPM_RX_DEPTH = 4;
  localparam int SPM_DLYBCT_UNIT = 32;
  localparam logic [3:0] SPM_MAX_LEN_CODE = 4'hC;
  localparam logic [4:0] SPM_MIN_BITS = 5'h04;
  localparam logic [4:0] SPM_MAX_BITS = 5'h10;
  localparam logic [3:0] SPM_PCS_IDLE = 4'hF;
  localparam logic SPM_SCLK_RST = 1'b0;
  localparam logic SPM_TX_READY_RST = 1'b1;

  // Per chip select setup: polarity, phase, length, divisor, delays
  typedef struct packed {
    logic clock_idle_polarity;
    logic clock_phase_bit;
    logic [3:0] len_code;
    logic [7:0] scbr;
    logic [7:0] dlybs;
    logic [7:0] dlybct;
  } spm_csel_cfg_t;

  // One character with its peripheral select code
  typedef struct packed {
    logic [3:0] pcs;
    logic [15:0] data;
  } spm_word_t;

  localparam int SPM_WORD_W = $bits(spm_word_t);

  typedef enum logic [2:0] {
    st_idle,
    st_gap,
    st_setup,
    st_shift,
    st_hold
  } spm_mstate_t;
endpackage

// *** rtl/spm_fifo.sv ***
// Small synchronous FIFO with a registered read port
`timescale 1ns/10ps
module spm_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic do_wr;
  logic do_rd;

  // Output register counts as storage, so capacity is exactly DEPTH
  assign in_ready = (32'(count) + (out_valid ? 32'd1 : 32'd0)) < DEPTH;
  assign do_wr = in_valid && in_ready;
  assign do_rd = (count != '0) && (!out_valid || out_ready);

  always_ff @(posedge clk_sys)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr <= (32'(wr_ptr) == DEPTH - 1) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr <= (32'(rd_ptr) == DEPTH - 1) ? '0 : rd_ptr + 1'b1;
        out_data <= mem[rd_ptr];
        out_valid <= 1'b1;
      end
      else if (out_ready)
      begin
        out_valid <= 1'b0;
      end
      count <= count + CW'(do_wr) - CW'(do_rd);
    end
  end

  a_fifo_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (32'(count) + (out_valid ? 32'd1 : 32'd0)) <= DEPTH)
    else $error("fifo holds more than its depth");
endmodule

// *** rtl/spm_core.sv ***
// Serial peripheral master/slave core with receive FIFO
// Overview of operation
// - Master: drive all four selects, clock and data-out; receive on data-in.
// - Slave: drive data-in, receive data-out, clock in, select 0 is slave select.
// - Slave leaves select lines 1 to 3 undriven.
// - Baud generator runs only in master mode.
// - Modes 0..3 are (pol,phase) = (0,1),(0,0),(1,1),(1,0).
// - Per-select polarity and phase choose launch and sample edges.
// - Master and slave must share polarity and phase.
// - Character length per select from 4 to 16 bits.
// - Four selects, optional external decode for 15 peripherals.
// - Per-select delays before clock and between transfers.
// - Mode fault detection can be enabled or disabled.
// - Separate receive and transmit DMA requests; chaining handled by DMA.
// - Receive FIFO holds four characters.
// - Master gives exactly one clock cycle per data bit.
// - Slave acts only while selected; master drives one select per slave unless pcs_decode is set.
// - One interrupt request output.
// - Same character settings in master and slave operation.
// - Master write to holding register starts shift out and sample in.
// - Master clock is the system clock divided by 2*(scbr+1), per-select scbr 1 to 255.
// - Character arriving at a full FIFO sets the overrun flag.
// - Selects sit high before and after each transfer.
`timescale 1ns/10ps
module spm_core (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic master_select_bit,
  input wire logic mode_fault_en,
  input wire logic variable_select,
  input wire logic pcs_decode,
  input wire logic [3:0] fixed_pcs,
  input wire logic [7:0] dly_between_cs,
  input wire spm_pkg::spm_csel_cfg_t [3:0] per_select_config,
  input wire logic tx_valid,
  input wire spm_pkg::spm_word_t tx_word,
  output logic tx_ready,
  output logic rx_valid,
  output spm_pkg::spm_word_t rx_word,
  input wire logic rx_ready,
  output logic overrun_flag,
  input wire logic overrun_clr,
  output logic mode_fault,
  input wire logic mode_fault_clr,
  output logic tx_empty,
  output logic dma_tx_req,
  output logic dma_rx_req,
  output logic irq,
  input wire logic serial_clock_in,
  output logic serial_clock_line,
  output logic serial_clock_oe,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic slave_select_input,
  output logic [3:0] peripheral_select_lines,
  output logic [3:0] peripheral_select_oe
);
  import spm_pkg::*;

  spm_mstate_t m_state;
  spm_word_t hold_word;
  spm_csel_cfg_t cur_cfg;
  spm_csel_cfg_t act_cfg;
  spm_word_t push_word;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] cur_pcs;
  logic [3:0] sel_pcs;
  logic [1:0] sel_idx;
  logic [3:0] sel_cs;
  logic [15:0] tx_sh;
  logic [15:0] rx_sh;
  logic [15:0] next_rx;
  logic [4:0] bit_cnt;
  logic [4:0] act_len;
  logic [7:0] brg_cnt;
  logic [12:0] dly_cnt;
  logic brg_tick;
  logic half;
  logic s_sclk_d;
  logic s_loaded;
  logic push;
  logic fifo_in_ready;
  logic master_on;
  logic slave_on;
  logic slave_sel;
  logic m_start;
  logic s_take;
  logic lead_ev;
  logic trail_ev;
  logic sample_ev;
  logic launch_ev;
  logic char_done;
  logic din;
  logic mf_event;
  logic sclk_s;
  logic mosi_s;
  logic miso_s;
  logic nss_s;

  function automatic logic [4:0] len_of(input logic [3:0] code);
    len_of = (code > SPM_MAX_LEN_CODE) ? SPM_MAX_BITS : {1'b0, code} + SPM_MIN_BITS;
  endfunction

  // Left-justify so the first bit out is always bit 15
  function automatic logic [15:0] align(input logic [15:0] d, input logic [4:0] len);
    align = d << (SPM_MAX_BITS - len);
  endfunction

  // Pins from outside pass two flops before use
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= SPM_PCS_IDLE;
      sync2 <= SPM_PCS_IDLE;
    end
    else
    begin
      sync1 <= {slave_select_input, miso_in, mosi_in, serial_clock_in};
      sync2 <= sync1;
    end
  end

  assign sclk_s = sync2[0];
  assign mosi_s = sync2[1];
  assign miso_s = sync2[2];
  assign nss_s = sync2[3];

  assign master_on = enable && master_select_bit;
  assign slave_on = enable && !master_select_bit;
  assign slave_sel = slave_on && !nss_s;

  // Peripheral select code and the config slot it uses
  always_comb
  begin
    sel_pcs = variable_select ? hold_word.pcs : fixed_pcs;
    sel_idx = 2'h3;
    sel_cs = SPM_PCS_IDLE;
    if (pcs_decode)
    begin
      sel_idx = sel_pcs[3:2];
      sel_cs = sel_pcs;
    end
    else
    begin
      for (int i = 3; i >= 0; i--)
      begin
        if (!sel_pcs[i])
        begin
          sel_idx = 2'(i);
          sel_cs = ~(4'h1 << i);
        end
      end
    end
  end

  // Slave always runs on slot 0 so both roles share one format
  assign act_cfg = master_select_bit ? cur_cfg : per_select_config[0];
  assign act_len = len_of(act_cfg.len_code);
  assign din = master_select_bit ? miso_s : mosi_s;
  assign m_start = master_on && (m_state == st_idle) && !tx_ready && !mode_fault;
  assign mf_event = master_on && mode_fault_en && !nss_s && peripheral_select_lines[0];

  // Leading edge leaves the idle level, trailing edge returns to it
  always_comb
  begin
    if (master_select_bit)
    begin
      lead_ev = master_on && (m_state == st_shift) && brg_tick && !half;
      trail_ev = master_on && (m_state == st_shift) && brg_tick && half;
    end
    else
    begin
      lead_ev = slave_sel && (sclk_s != s_sclk_d) && (sclk_s != act_cfg.clock_idle_polarity);
      trail_ev = slave_sel && (sclk_s != s_sclk_d) && (sclk_s == act_cfg.clock_idle_polarity);
    end
    sample_ev = act_cfg.clock_phase_bit ? lead_ev : trail_ev;
    launch_ev = act_cfg.clock_phase_bit ? (trail_ev && (bit_cnt != act_len - 5'h01))
                              : (lead_ev && (bit_cnt != 5'h00));
    char_done = trail_ev && (bit_cnt == act_len - 5'h01);
    next_rx = sample_ev ? {rx_sh[14:0], din} : rx_sh;
  end

  assign s_take = slave_on && !tx_ready && ((nss_s && !s_loaded) || char_done);

  // Bit rate divider, halted outside master shifting
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      brg_cnt <= 8'h00;
      brg_tick <= 1'b0;
    end
    else if (!(master_on && m_state == st_shift) || brg_tick)
    begin
      brg_cnt <= 8'h00;
      brg_tick <= 1'b0;
    end
    else if (brg_cnt + 8'h01 >= cur_cfg.scbr)
    begin
      brg_cnt <= 8'h00;
      brg_tick <= 1'b1;
    end
    else
    begin
      brg_cnt <= brg_cnt + 8'h01;
    end
  end

  // Master sequencer: select gap, setup delay, shifting, hold delay
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      m_state <= st_idle;
      dly_cnt <= 13'h0000;
      cur_cfg <= '0;
      cur_pcs <= SPM_PCS_IDLE;
    end
    else if (!master_on || mf_event)
    begin
      m_state <= st_idle;
    end
    else
    begin
      unique case (m_state)
        st_idle:
        begin
          if (m_start)
          begin
            cur_cfg <= per_select_config[sel_idx];
            cur_pcs <= sel_cs;
            dly_cnt <= {5'h00, dly_between_cs};
            m_state <= st_gap;
          end
        end
        st_gap:
        begin
          if (dly_cnt == 13'h0000)
          begin
            dly_cnt <= {5'h00, cur_cfg.dlybs};
            m_state <= st_setup;
          end
          else
          begin
            dly_cnt <= dly_cnt - 13'h0001;
          end
        end
        st_setup:
        begin
          if (dly_cnt == 13'h0000)
          begin
            m_state <= st_shift;
          end
          else
          begin
            dly_cnt <= dly_cnt - 13'h0001;
          end
        end
        st_shift:
        begin
          if (char_done)
          begin
            dly_cnt <= 13'(int'(cur_cfg.dlybct) * SPM_DLYBCT_UNIT);
            m_state <= st_hold;
          end
        end
        st_hold:
        begin
          if (dly_cnt == 13'h0000)
          begin
            m_state <= st_idle;
          end
          else
          begin
            dly_cnt <= dly_cnt - 13'h0001;
          end
        end
      endcase
    end
  end

  // Shift registers and serial clock
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_sh <= 16'h0000;
      rx_sh <= 16'h0000;
      bit_cnt <= 5'h00;
      half <= 1'b0;
      serial_clock_line <= SPM_SCLK_RST;
      s_sclk_d <= SPM_SCLK_RST;
      s_loaded <= 1'b0;
      push <= 1'b0;
      push_word <= '0;
    end
    else
    begin
      s_sclk_d <= sclk_s;
      push <= char_done;
      push_word <= {(master_select_bit ? cur_pcs : 4'h0), next_rx};
      if (m_start)
      begin
        tx_sh <= align(hold_word.data, len_of(per_select_config[sel_idx].len_code));
        rx_sh <= 16'h0000;
        bit_cnt <= 5'h00;
        half <= 1'b0;
        serial_clock_line <= per_select_config[sel_idx].clock_idle_polarity;
      end
      else if (slave_on && nss_s)
      begin
        rx_sh <= 16'h0000;
        bit_cnt <= 5'h00;
      end
      else
      begin
        rx_sh <= char_done ? 16'h0000 : next_rx;
        if (launch_ev)
        begin
          tx_sh <= {tx_sh[14:0], 1'b0};
        end
        if (lead_ev)
        begin
          half <= 1'b1;
          serial_clock_line <= ~cur_cfg.clock_idle_polarity;
        end
        if (trail_ev)
        begin
          half <= 1'b0;
          serial_clock_line <= cur_cfg.clock_idle_polarity;
          bit_cnt <= char_done ? 5'h00 : bit_cnt + 5'h01;
        end
      end
      if (s_take)
      begin
        tx_sh <= align(hold_word.data, act_len);
        s_loaded <= 1'b1;
      end
      else if (char_done || !slave_on)
      begin
        s_loaded <= 1'b0;
      end
    end
  end

  assign mosi_out = tx_sh[15];
  assign miso_out = tx_sh[15];

  // Transmit holding register; freed once moved into the shifter
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_ready <= SPM_TX_READY_RST;
      hold_word <= '0;
    end
    else if (tx_valid && tx_ready)
    begin
      tx_ready <= 1'b0;
      hold_word <= tx_word;
    end
    else if (m_start || s_take)
    begin
      tx_ready <= 1'b1;
    end
  end

  // Pin direction per role
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      peripheral_select_lines <= SPM_PCS_IDLE;
      peripheral_select_oe <= 4'h0;
      serial_clock_oe <= 1'b0;
      mosi_oe <= 1'b0;
      miso_oe <= 1'b0;
    end
    else
    begin
      peripheral_select_oe <= master_on ? 4'hF : 4'h0;
      serial_clock_oe <= master_on;
      mosi_oe <= master_on;
      miso_oe <= slave_sel;
      if (master_on && (m_state == st_setup || m_state == st_shift || m_state == st_hold))
      begin
        peripheral_select_lines <= cur_pcs;
      end
      else
      begin
        peripheral_select_lines <= SPM_PCS_IDLE;
      end
    end
  end

  // Dropped characters on overrun; the flag tells software to recover
  spm_fifo #(
    .WIDTH(SPM_WORD_W),
    .DEPTH(SPM_RX_DEPTH)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .in_valid(push),
    .in_data(push_word),
    .in_ready(fifo_in_ready),
    .out_valid(rx_valid),
    .out_data(rx_word),
    .out_ready(rx_ready)
  );

  // Sticky flags, set wins over clear; status and requests
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overrun_flag <= 1'b0;
      mode_fault <= 1'b0;
      tx_empty <= 1'b1;
      dma_tx_req <= 1'b0;
      dma_rx_req <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      overrun_flag <= (push && !fifo_in_ready) || (overrun_flag && !overrun_clr);
      mode_fault <= mf_event || (mode_fault && !mode_fault_clr);
      tx_empty <= tx_ready && (m_state == st_idle);
      dma_tx_req <= enable && tx_ready && !(tx_valid && tx_ready);
      dma_rx_req <= enable && rx_valid && !rx_ready;
      irq <= enable && (overrun_flag || mode_fault || rx_valid);
    end
  end

  // Checks
  logic [4:0] edge_cnt;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      edge_cnt <= 5'h00;
    end
    else if (m_start)
    begin
      edge_cnt <= 5'h00;
    end
    else if (master_select_bit && lead_ev)
    begin
      edge_cnt <= edge_cnt + 5'h01;
    end
  end

  a_master_pins: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(master_on) |-> (serial_clock_oe && mosi_oe && !miso_oe && peripheral_select_oe == 4'hF))
    else $error("master pin directions wrong");
  a_slave_pins: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(slave_on) |-> (!serial_clock_oe && !mosi_oe && !peripheral_select_oe[0]))
    else $error("slave pin directions wrong");
  a_slave_free_cs: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(!master_on) |-> (peripheral_select_oe[3:1] == 3'h0))
    else $error("slave drives spare selects");
  a_no_baud_slave: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !master_select_bit |=> !brg_tick)
    else $error("baud generator ran in slave mode");
  a_bits_per_char: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (master_on && m_state == st_shift && char_done) |-> (edge_cnt == act_len))
    else $error("clock count differs from character length");
  a_overrun_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (push && !fifo_in_ready) |=> overrun_flag)
    else $error("overrun not flagged");
  a_cs_idle_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (m_state == st_idle && $past(m_state) == st_idle) |-> (peripheral_select_lines == 4'hF))
    else $error("select low outside a transfer");
  a_cs_one_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !pcs_decode |-> ($countones(~peripheral_select_lines) <= 1))
    else $error("more than one select low");
  a_sclk_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (master_on && m_state == st_setup) |-> (serial_clock_line == cur_cfg.clock_idle_polarity))
    else $error("clock not at idle level before shifting");
  a_start_frees: assert property (@(posedge clk_sys) disable iff (!rst_n)
    m_start |=> (tx_ready && m_state == st_gap))
    else $error("write did not start a transfer");

  c_master_char: cover property (@(posedge clk_sys) disable iff (!rst_n)
    master_on && char_done);
  c_slave_char: cover property (@(posedge clk_sys) disable iff (!rst_n)
    slave_on && char_done);
  c_overrun: cover property (@(posedge clk_sys) disable iff (!rst_n)
    push && !fifo_in_ready);
  c_mode_fault: cover property (@(posedge clk_sys) disable iff (!rst_n) mf_event);
endmodule

// *** bench/spm_slave_model.sv ***
// Behavioural serial slave that faces the core in master mode
`timescale 1ns/10ps
module spm_slave_model (
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic mosi,
  input wire logic clock_idle_polarity,
  input wire logic clock_phase_bit,
  input wire logic [4:0] bits,
  input wire logic [15:0] reply,
  output logic miso,
  output logic [15:0] got
);
  logic [15:0] sr;
  initial
  begin
    miso = 1'b0;
    got = 16'h0000;
    sr = 16'h0000;
  end
  // Left-align the reply so the msb of the character leaves first
  always @(negedge sel_n)
  begin
    got = 16'h0000;
    sr = reply << (5'h10 - bits);
    if (clock_phase_bit)
    begin
      miso = sr[15];
      sr = sr << 1;
    end
  end
  // Released line flips so a stale bit never looks valid
  always @(posedge sel_n) miso = ~miso;
  // Leading edge is the move away from idle; phase picks sample or launch
  always @(sclk)
  begin
    if (!sel_n && ((sclk != clock_idle_polarity) == clock_phase_bit)) got = {got[14:0], mosi};
    else if (!sel_n)
    begin
      miso = sr[15];
      sr = sr << 1;
    end
  end
endmodule

// *** bench/spm_core_bench.sv ***
// Self-checking bench for the serial master/slave core
`timescale 1ns/10ps
module spm_core_bench;
  import spm_pkg::*;
  logic clk_sys, rst_n, enable, master_select_bit, mode_fault_en, variable_select, pcs_decode;
  logic tx_valid, tx_ready, rx_valid, rx_ready, overrun_flag, overrun_clr, mode_fault;
  logic mode_fault_clr, tx_empty, dma_tx_req, dma_rx_req, irq, serial_clock_in;
  logic serial_clock_line, serial_clock_oe, mosi_in, mosi_out, mosi_oe, miso_in, miso_out;
  logic miso_oe, slave_select_input, sclk_q, model_sel_n, cnt_clr;
  logic [3:0] fixed_pcs, peripheral_select_lines, peripheral_select_oe;
  logic [7:0] dly_between_cs;
  logic [4:0] nbits;
  logic [15:0] reply, got, mask;
  spm_csel_cfg_t cfg;
  spm_csel_cfg_t [3:0] psc;
  spm_word_t tx_word, rx_word;
  int bad_count, tests_run, edges, lead, tail;

  assign model_sel_n = !(master_select_bit && peripheral_select_oe[0])
    || (peripheral_select_lines === SPM_PCS_IDLE);

  spm_core u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .enable(enable),
    .master_select_bit(master_select_bit), .mode_fault_en(mode_fault_en),
    .variable_select(variable_select), .pcs_decode(pcs_decode), .fixed_pcs(fixed_pcs),
    .dly_between_cs(dly_between_cs), .per_select_config(psc), .tx_valid(tx_valid),
    .tx_word(tx_word), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_word(rx_word),
    .rx_ready(rx_ready), .overrun_flag(overrun_flag), .overrun_clr(overrun_clr),
    .mode_fault(mode_fault), .mode_fault_clr(mode_fault_clr), .tx_empty(tx_empty),
    .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req), .irq(irq),
    .serial_clock_in(serial_clock_in), .serial_clock_line(serial_clock_line),
    .serial_clock_oe(serial_clock_oe), .mosi_in(mosi_in), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_in(miso_in), .miso_out(miso_out), .miso_oe(miso_oe),
    .slave_select_input(slave_select_input),
    .peripheral_select_lines(peripheral_select_lines),
    .peripheral_select_oe(peripheral_select_oe));

  spm_slave_model u_slave (.sclk(serial_clock_line), .sel_n(model_sel_n), .mosi(mosi_out),
    .clock_idle_polarity(cfg.clock_idle_polarity), .clock_phase_bit(cfg.clock_phase_bit), .bits(nbits), .reply(reply), .miso(miso_in),
    .got(got));

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Edge, lead-in and hold counts while any select is low
  always @(posedge clk_sys)
  begin
    sclk_q <= serial_clock_line;
    if (cnt_clr)
    begin
      edges <= 0;
      lead <= 0;
      tail <= 0;
    end
    else if (peripheral_select_lines !== SPM_PCS_IDLE && serial_clock_line !== sclk_q)
    begin
      edges <= edges + 1;
      tail <= 0;
    end
    else if (peripheral_select_lines !== SPM_PCS_IDLE)
    begin
      tail <= tail + 1;
      lead <= lead + ((edges == 0) ? 1 : 0);
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic timeout;
    bad_count++;
    finish_test();
  endtask

  task automatic send(input logic [15:0] d, input logic [3:0] pcs);
    int i;
    for (i = 0; i < 2000 && tx_ready !== 1'b1; i++) step(1);
    if (i == 2000) timeout();
    tx_word = '{pcs: pcs, data: d};
    tx_valid = 1'b1;
    step(1);
    tx_valid = 1'b0;
  endtask

  task automatic pop;
    int i;
    for (i = 0; i < 500 && rx_valid !== 1'b1; i++) step(1);
    if (i == 500) timeout();
    rx_ready = 1'b1;
    step(1);
    rx_ready = 1'b0;
    step(2);
  endtask

  // One master character; slot settings copied to all four selects
  task automatic xfer(input logic cp, input logic nc, input logic [3:0] lc,
    input logic [15:0] d, input logic [3:0] pcs, input logic [3:0] esel,
    input logic [7:0] ct, input logic rd);
    int i;
    cfg = '{clock_idle_polarity: cp, clock_phase_bit: nc, len_code: lc, scbr: 8'h03, dlybs: 8'h06, dlybct: ct};
    psc = {4{cfg}};
    nbits = (lc > SPM_MAX_LEN_CODE) ? SPM_MAX_BITS : {1'b0, lc} + SPM_MIN_BITS;
    mask = 16'hFFFF >> (5'h10 - nbits);
    reply = ~d ^ 16'h0F0F;
    cnt_clr = 1'b1;
    step(2);
    cnt_clr = 1'b0;
    send(d, pcs);
    for (i = 0; i < 2000 && peripheral_select_lines === SPM_PCS_IDLE; i++) step(1);
    if (i == 2000) timeout();
    check(peripheral_select_lines, esel);
    for (i = 0; i < 4000 && peripheral_select_lines !== SPM_PCS_IDLE; i++) step(1);
    if (i == 4000) timeout();
    step(1);
    check(edges, 2 * nbits);
    check(got, d & mask);
    check(lead >= 6, 1);
    check(tail >= 32 * ct, 1);
    check(serial_clock_line, cp);
    check({tx_empty, dma_tx_req}, 2'h3);
    if (rd)
    begin
      for (i = 0; i < 500 && rx_valid !== 1'b1; i++) step(1);
      if (i == 500) timeout();
      check(rx_word.data, reply & mask);
      check(dma_rx_req, 1);
      step(1);
      check(irq, 1);
      pop();
    end
  endtask

  initial
  begin
    bad_count = 0;
    tests_run = 0;
    {rst_n, enable, mode_fault_en, pcs_decode, tx_valid, rx_ready} = 6'h00;
    {overrun_clr, mode_fault_clr, serial_clock_in, mosi_in, cnt_clr} = 5'h00;
    {master_select_bit, variable_select, slave_select_input} = 3'h7;
    fixed_pcs = 4'hE;
    dly_between_cs = 8'h01;
    cfg = '0;
    psc = '0;
    tx_word = '0;
    repeat (6) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    check(peripheral_select_lines, SPM_PCS_IDLE);
    enable = 1'b1;
    step(2);
    check({peripheral_select_oe, serial_clock_oe, mosi_oe, miso_oe}, 7'h7E);
    // Four modes, lengths from minimum to capped maximum
    xfer(1'b0, 1'b1, 4'h4, 16'h00A6, 4'hE, 4'hE, 8'h00, 1'b1);
    xfer(1'b0, 1'b0, 4'h0, 16'h0009, 4'hD, 4'hD, 8'h00, 1'b1);
    xfer(1'b1, 1'b1, 4'hC, 16'hB38D, 4'hB, 4'hB, 8'h00, 1'b1);
    xfer(1'b1, 1'b0, 4'hF, 16'h6C1F, 4'h7, 4'h7, 8'h01, 1'b1);
    // Two lows in a fixed code: lowest numbered wins
    variable_select = 1'b0;
    fixed_pcs = 4'h6;
    xfer(1'b0, 1'b1, 4'h4, 16'h0055, 4'h7, 4'hE, 8'h00, 1'b1);
    variable_select = 1'b1;
    pcs_decode = 1'b1;
    xfer(1'b0, 1'b1, 4'h4, 16'h00C3, 4'h5, 4'h5, 8'h00, 1'b1);
    pcs_decode = 1'b0;
    // Fill the receive queue without reading, then once more
    for (int n = 0; n < 5; n++)
    begin
      xfer(1'b0, 1'b0, 4'h4, 16'h0011 * n, 4'hE, 4'hE, 8'h00, 1'b0);
      if (n == 3) check(overrun_flag, 0);
    end
    step(3);
    check(overrun_flag, 1);
    // Oldest first; the fifth character was dropped
    for (int n = 0; n < 4; n++)
    begin
      check(rx_word.data, (~(16'h0011 * n) ^ 16'h0F0F) & 16'h00FF);
      pop();
    end
    check(rx_valid, 0);
    overrun_clr = 1'b1;
    step(1);
    overrun_clr = 1'b0;
    step(2);
    check(overrun_flag, 0);
    // Foreign select pulled low while we are master
    for (int n = 1; n >= 0; n--)
    begin
      mode_fault_en = n[0];
      slave_select_input = 1'b0;
      step(4);
      slave_select_input = 1'b1;
      step(2);
      check(mode_fault, n);
      mode_fault_clr = 1'b1;
      step(1);
      mode_fault_clr = 1'b0;
      step(2);
    end
    // Slave mode; bench plays master with a slow clock
    master_select_bit = 1'b0;
    cfg = '{clock_idle_polarity: 1'b0, clock_phase_bit: 1'b1, len_code: 4'h4, scbr: 8'h03, dlybs: 8'h00, dlybct: 8'h00};
    psc = {4{cfg}};
    send(16'h00C3, 4'h0);
    step(2);
    slave_select_input = 1'b0;
    step(6);
    check({miso_oe, mosi_oe, serial_clock_oe, peripheral_select_oe}, 7'h40);
    for (int k = 7; k >= 0; k--)
    begin
      mosi_in = k[0] ^ k[2];
      step(6);
      check(miso_out, (8'hC3 >> k) & 8'h01);
      serial_clock_in = 1'b1;
      step(6);
      serial_clock_in = 1'b0;
    end
    step(6);
    slave_select_input = 1'b1;
    mosi_in = ~mosi_in;
    step(12);
    check(rx_word, {4'h0, 16'h005A});
    // Disable before any clock gating: pins released, requests quiet
    enable = 1'b0;
    step(2);
    check({peripheral_select_oe, serial_clock_oe, mosi_oe, miso_oe}, 7'h00);
    check({irq, dma_rx_req, dma_tx_req, peripheral_select_lines}, 7'h0F);
    finish_test();
  end
endmodule
